// ==== bench/cst_partner.sv ====
`timescale 1ns/1ps
module cst_partner (
  // Clock
  input wire logic ref_clk_in,
  // Peer timebase and converters
  input wire logic peer_en_in,
  input wire logic [1:0] good_in,
  input wire logic [1:0] vout_en_in,
  // Shared line
  input wire logic dut_oe_in,
  output logic share_line_out,
  output logic [1:0] uv_ok_out
);
  logic [8:0] peer_cnt_reg = 9'h000;
  logic [1:0][11:0] rise_cnt_reg = '0;
  // ****************
  // Peer timebase
  // ****************
  // Peer runs faster than the block so its falling edges set the pace
  always_ff @(posedge ref_clk_in) begin
    peer_cnt_reg <= (peer_cnt_reg == 9'h12b) ? 9'h000 : peer_cnt_reg + 9'h001;
  end
  // Pull-up wins only when no party pulls low
  assign share_line_out = !(dut_oe_in || (peer_en_in && peer_cnt_reg < 9'h064));
  // ****************
  // Converters
  // ****************
  // A healthy output crosses its undervoltage level 2000 cycles after enable
  always_ff @(posedge ref_clk_in) begin
    for (int i = 0; i < 2; i++) begin
      if (!vout_en_in[i]) begin
        rise_cnt_reg[i] <= 12'h000;
      end else if (rise_cnt_reg[i] != 12'h7d0) begin
        rise_cnt_reg[i] <= rise_cnt_reg[i] + 12'h001;
      end
    end
  end
  assign uv_ok_out[0] = good_in[0] && rise_cnt_reg[0] == 12'h7d0;
  assign uv_ok_out[1] = good_in[1] && rise_cnt_reg[1] == 12'h7d0;
endmodule

// ==== bench/tb_cst_channel_sequence_timers.sv ====
`timescale 1ns/1ps
`include "cst_cfg.svh"
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin failures++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module tb_cst_channel_sequence_timers;
  import cst_pkg::*;
  logic ref_clk_in;
  logic reset_n_in = 1'b0;
  logic pm_wr_in = 1'b0;
  logic pm_page_in = 1'b0;
  logic [7:0] pm_cmd_in = 8'h00;
  logic [15:0] pm_wdata_in = 16'h0000;
  logic [15:0] pm_rdata_out;
  logic control_in = 1'b1;
  logic operation_on_in = 1'b0;
  logic vin_share_en_in = 1'b0;
  logic vin_ok_in = 1'b1;
  logic [1:0] good = 2'b01;
  logic [1:0] uv_ok, en, servo, msk, flt;
  logic line, oe, sc_out;
  cst_chan_input_type [1:0] chan_in;
  cst_chan_status_type [1:0] st;
  int failures = 0;
  int samples_checked = 0;
  int c;
  logic [7:0] cmds [5] = '{8'h60, 8'h61, 8'h62, 8'h64, 8'hdc};
  logic [15:0] defs [5] = '{16'hba00, 16'hd280, 16'hd3c0, 16'hba00, 16'hfb20};

  assign chan_in[0] = {2'b00, uv_ok[0]};
  assign chan_in[1] = {2'b01, uv_ok[1]};
  assign en = {st[1].vout_en, st[0].vout_en};
  assign servo = {st[1].dac_servo, st[0].dac_servo};
  assign msk = {st[1].uv_masked, st[0].uv_masked};
  assign flt = {st[1].ton_max_fault, st[0].ton_max_fault};

  cst_channel_sequence_timers cst_channel_sequence_timers_inst (.ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in), .pm_wr_in(pm_wr_in), .pm_page_in(pm_page_in),
    .pm_cmd_in(pm_cmd_in), .pm_wdata_in(pm_wdata_in), .pm_rdata_out(pm_rdata_out),
    .control_in(control_in), .operation_on_in(operation_on_in),
    .vin_share_en_in(vin_share_en_in), .vin_ok_in(vin_ok_in), .chan_in(chan_in),
    .share_clk_in(line), .share_clk_out(sc_out), .share_clk_oe_out(oe),
    .chan_status_out(st));
  cst_partner cst_partner_inst (.ref_clk_in(ref_clk_in), .peer_en_in(1'b1), .good_in(good),
    .vout_en_in(en), .dut_oe_in(oe), .share_line_out(line), .uv_ok_out(uv_ok));

  // ****************
  // Tasks
  // ****************
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Counts falling edges of the shared line; c holds the cycles spent
  task automatic ticks(input int n);
    logic p, q;
    int k;
    k = 0;
    c = 0;
    q = line;
    while (k < n) begin
      @(negedge ref_clk_in);
      c++;
      p = q;
      q = line;
      if (p && !q) k++;
      if (c > n * 400 + 400) begin
        failures++;
        $display("timeout waiting for timebase");
        stop_test();
      end
    end
  endtask

  task automatic rd(input logic pg, input logic [7:0] cmd, input logic [15:0] ex);
    @(negedge ref_clk_in);
    pm_page_in = pg;
    pm_cmd_in = cmd;
    repeat (2) @(negedge ref_clk_in);
    `CHK("readback", ex, pm_rdata_out)
  endtask

  task automatic wrd(input logic pg, input logic [7:0] cmd, input logic [15:0] d);
    @(negedge ref_clk_in);
    pm_wr_in = 1'b1;
    pm_page_in = pg;
    pm_cmd_in = cmd;
    pm_wdata_in = d;
    @(negedge ref_clk_in);
    pm_wr_in = 1'b0;
    rd(pg, cmd, d);
  endtask

  // ****************
  // Sequence
  // ****************
  initial begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end

  initial begin
    repeat (6) @(negedge ref_clk_in);
    reset_n_in = 1'b1;
    foreach (cmds[i]) rd(1'b0, cmds[i], defs[i]);
    rd(1'b0, 8'h65, 16'h0000);
    wrd(1'b0, 8'hdc, 16'hfbff);
    for (int p = 0; p < 2; p++) begin
      wrd(p[0], 8'h60, 16'haa00);
      wrd(p[0], 8'h61, 16'hb900);
      wrd(p[0], 8'h62, 16'haa00);
      wrd(p[0], 8'h64, 16'haa00);
    end
    wrd(1'b0, 8'hdc, 16'hb266);
    $display("test registers done");
    ticks(1);
    ticks(1);
    `CHK("tick period", 300, c)
    `CHK("line drive level", 1'b0, sc_out)
    operation_on_in = 1'b1;
    ticks(22);
    `CHK("enable early", 2'b00, en)
    ticks(6);
    `CHK("enable", 2'b11, en)
    ticks(18);
    `CHK("uv mask", 2'b10, msk)
    `CHK("timeout early", 2'b00, flt)
    ticks(10);
    `CHK("timeout", 2'b10, flt)
    ticks(14);
    `CHK("servo early", 2'b00, servo)
    ticks(10);
    `CHK("servo", 2'b01, servo)
    $display("test power up done");
    operation_on_in = 1'b0;
    ticks(22);
    `CHK("off early", 2'b11, en)
    ticks(6);
    `CHK("off", 2'b00, en)
    wrd(1'b1, 8'h62, 16'h0000);
    operation_on_in = 1'b1;
    ticks(28);
    ticks(28);
    `CHK("no limit", 2'b00, flt)
    $display("test turn off and no limit done");
    // Off for 1000 cycles is past the minimum off time but well inside the restart time
    control_in = 1'b0;
    repeat (1000) @(negedge ref_clk_in);
    control_in = 1'b1;
    repeat (10) @(negedge ref_clk_in);
    `CHK("restart off", 2'b00, en)
    ticks(50);
    `CHK("restart hold", 2'b00, en)
    ticks(40);
    `CHK("restart on", 2'b11, en)
    wrd(1'b0, 8'hdc, 16'h0000);
    control_in = 1'b0;
    repeat (1000) @(negedge ref_clk_in);
    control_in = 1'b1;
    ticks(3);
    `CHK("restart disabled", 2'b11, en)
    $display("test restart done");
    vin_share_en_in = 1'b1;
    vin_ok_in = 1'b0;
    repeat (5) @(negedge ref_clk_in);
    `CHK("line held", 1'b1, oe)
    repeat (1000) @(negedge ref_clk_in);
    `CHK("vin off", 2'b00, en)
    vin_ok_in = 1'b1;
    ticks(28);
    `CHK("vin restart", 2'b11, en)
    $display("test input share done");
    stop_test();
  end
endmodule

// ==== rtl/cst_cfg.svh ====
`ifndef CST_CFG_SVH
`define CST_CFG_SVH
// Summary of operation
// - After an on sequence starts, wait the turn-on delay before enabling the converter.
// - Turn-on, settle, timeout and restart times count shared timebase ticks only.
// - After control or command goes off, wait turn-off delay, then soft-off.
// - Turn-off delay uses shared timebase if present, else the internal oscillator.
// - With DAC mode 00, wait settle time after enable, then connect DAC and servo.
// - Output below undervoltage limit past the timeout after enable raises a fault.
// - Undervoltage threshold masked during power-up, unmasked once output reaches it.
// - A timeout limit of zero disables the turn-on timeout entirely.
// - On/off delays clamp at 13.1 s; 10 us steps below 655 ms, else 200 us.
// - Settle time and timeout limit clamp at 655 ms, rounded to 10 us.
// - Reading a timing setting returns the value last written, unclamped.
// - Control off at least 10 us then on holds channels off restart time, then resequences.
// - A control off interval longer than the restart time is handled normally.
// - A restart off time of zero disables the control restart feature.
// - Restart off time clamps at 13.1 s, rounds to 200 us, reads back as written.
// - One restart time for both channels, from real to virtual control active edge.
// - Shared open-drain timebase: fastest clock wins, all sync to its falling edge.
// - With input share enabled, hold the timebase line low while input voltage is low.
// - With input share enabled, a line held low disables both channels after deglitch.
// - With input share enabled, release of the line starts a new on sequence.

// ********************
// Command codes
// ********************
`define CST_CMD_TURN_ON_DELAY 8'h60
`define CST_CMD_SETTLE 8'h61
`define CST_CMD_TON_MAX 8'h62
`define CST_CMD_TURN_OFF_DELAY 8'h64
`define CST_CMD_RESTART 8'hdc

// ********************
// Reset values
// ********************
`define CST_RST_TURN_ON_DELAY 16'hba00
`define CST_RST_SETTLE 16'hd280
`define CST_RST_TON_MAX 16'hd3c0
`define CST_RST_TURN_OFF_DELAY 16'hba00
`define CST_RST_RESTART 16'hfb20

// ********************
// Timing
// ********************
`define CST_CLK_MHZ 40
`define CST_TICK_US 10
`define CST_TICK_CYC (`CST_CLK_MHZ * `CST_TICK_US)
`define CST_TICKS_PER_MS (1000 / `CST_TICK_US)
`define CST_SHORT_MS 655
`define CST_LONG_MS 13100
`define CST_SHORT_TICKS (`CST_SHORT_MS * `CST_TICKS_PER_MS)
`define CST_LONG_TICKS (`CST_LONG_MS * `CST_TICKS_PER_MS)
`define CST_COARSE_US 200
`define CST_COARSE_TICKS (`CST_COARSE_US / `CST_TICK_US)
`define CST_MIN_OFF_US 10
`define CST_MIN_OFF_CYC (`CST_CLK_MHZ * `CST_MIN_OFF_US)
`define CST_DEGLITCH_US 20
`define CST_DEGLITCH_CYC (`CST_CLK_MHZ * `CST_DEGLITCH_US)
`define CST_PRESENT_US 30
`define CST_PRESENT_CYC (`CST_CLK_MHZ * `CST_PRESENT_US)

// ********************
// Field positions
// ********************
`define CST_L11_MANT_MSB 10
`define CST_L11_EXP_LSB 11
`define CST_DAC_MODE_SERVO 2'h0
`endif

// ==== rtl/cst_channel_sequence_timers.sv ====
`timescale 1ns/1ps
`include "cst_cfg.svh"
module cst_channel_sequence_timers (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  // Command port
  input wire logic pm_wr_in,
  input wire logic pm_page_in,
  input wire logic [7:0] pm_cmd_in,
  input wire logic [15:0] pm_wdata_in,
  output logic [15:0] pm_rdata_out,
  // Sequencing requests
  input wire logic control_in,
  input wire logic operation_on_in,
  input wire logic vin_share_en_in,
  input wire logic vin_ok_in,
  // Per channel inputs
  input wire cst_pkg::cst_chan_input_type [1:0] chan_in,
  // Shared timebase pin
  input wire logic share_clk_in,
  output logic share_clk_out,
  output logic share_clk_oe_out,
  // Per channel status
  output cst_pkg::cst_chan_status_type [1:0] chan_status_out
);
  import cst_pkg::*;
  // ********************
  // Timing settings
  // ********************
  logic [15:0] ton_reg [2];
  logic [15:0] settle_reg [2];
  logic [15:0] tmax_reg [2];
  logic [15:0] toff_reg [2];
  logic [15:0] restart_reg;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < 2; i++) begin
        ton_reg[i] <= `CST_RST_TURN_ON_DELAY;
        settle_reg[i] <= `CST_RST_SETTLE;
        tmax_reg[i] <= `CST_RST_TON_MAX;
        toff_reg[i] <= `CST_RST_TURN_OFF_DELAY;
      end
      restart_reg <= `CST_RST_RESTART;
    end else if (pm_wr_in) begin
      if (pm_cmd_in == `CST_CMD_TURN_ON_DELAY) begin
        ton_reg[pm_page_in] <= pm_wdata_in;
      end else if (pm_cmd_in == `CST_CMD_SETTLE) begin
        settle_reg[pm_page_in] <= pm_wdata_in;
      end else if (pm_cmd_in == `CST_CMD_TON_MAX) begin
        tmax_reg[pm_page_in] <= pm_wdata_in;
      end else if (pm_cmd_in == `CST_CMD_TURN_OFF_DELAY) begin
        toff_reg[pm_page_in] <= pm_wdata_in;
      end else if (pm_cmd_in == `CST_CMD_RESTART) begin
        restart_reg <= pm_wdata_in;
      end
    end
  end
  // Readback shows the stored word, never the clamped tick count
  always_comb begin
    if (pm_cmd_in == `CST_CMD_TURN_ON_DELAY) begin
      rdata_next = ton_reg[pm_page_in];
    end else if (pm_cmd_in == `CST_CMD_SETTLE) begin
      rdata_next = settle_reg[pm_page_in];
    end else if (pm_cmd_in == `CST_CMD_TON_MAX) begin
      rdata_next = tmax_reg[pm_page_in];
    end else if (pm_cmd_in == `CST_CMD_TURN_OFF_DELAY) begin
      rdata_next = toff_reg[pm_page_in];
    end else if (pm_cmd_in == `CST_CMD_RESTART) begin
      rdata_next = restart_reg;
    end else begin
      rdata_next = 16'h0;
    end
  end
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_reg <= 16'h0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end
  assign pm_rdata_out = rdata_reg;
  // ********************
  // Shared timebase
  // ********************
  logic [8:0] osc_cnt_reg;
  logic share_prev_reg;
  logic share_fall;
  logic osc_tick;
  logic [10:0] since_fall_reg;
  logic [9:0] low_cnt_reg;
  logic share_present;
  logic share_held_low;
  logic vin_drive_low;
  assign share_fall = share_prev_reg && !share_clk_in;
  assign osc_tick = (osc_cnt_reg == 9'(`CST_TICK_CYC - 1));
  assign share_present = (since_fall_reg < 11'(`CST_PRESENT_CYC));
  assign share_held_low = (low_cnt_reg >= 10'(`CST_DEGLITCH_CYC));
  assign vin_drive_low = vin_share_en_in && !vin_ok_in;
  // Restarting the divider on every falling edge lets the fastest device lead
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      osc_cnt_reg <= 9'h0;
    end else if (share_fall || osc_tick) begin
      osc_cnt_reg <= 9'h0;
    end else begin
      osc_cnt_reg <= osc_cnt_reg + 9'h1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      share_prev_reg <= 1'b1;
      since_fall_reg <= 11'(`CST_PRESENT_CYC);
      low_cnt_reg <= 10'h0;
    end else begin
      share_prev_reg <= share_clk_in;
      if (share_fall) begin
        since_fall_reg <= 11'h0;
      end else if (share_present) begin
        since_fall_reg <= since_fall_reg + 11'h1;
      end
      if (share_clk_in) begin
        low_cnt_reg <= 10'h0;
      end else if (!share_held_low) begin
        low_cnt_reg <= low_cnt_reg + 10'h1;
      end
    end
  end
  // Open drain: low half of each period, or held low while input voltage is short
  assign share_clk_out = 1'b0;
  assign share_clk_oe_out = (osc_cnt_reg < 9'(`CST_TICK_CYC / 2)) || vin_drive_low;
  // ********************
  // Control restart
  // ********************
  logic ctrl_prev_reg;
  logic [8:0] off_cyc_reg;
  logic [20:0] off_ticks_reg;
  logic [20:0] hold_cnt_reg;
  logic hold_reg;
  logic [20:0] restart_ticks;
  logic ctrl_rise;
  logic ctrl_fall;
  logic restart_hit;
  cst_l11_ticks u_restart_conv (
    .l11_in(restart_reg),
    .mode_in(CST_CLAMP_RESTART),
    .ticks_out(restart_ticks)
  );

  assign ctrl_rise = control_in && !ctrl_prev_reg;
  assign ctrl_fall = !control_in && ctrl_prev_reg;
  // Short pulses below 10 us and long off times fall through untouched
  assign restart_hit = ctrl_rise && (restart_ticks != 21'h0) &&
                       (off_cyc_reg == 9'(`CST_MIN_OFF_CYC)) &&
                       (off_ticks_reg < restart_ticks);

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl_prev_reg <= 1'b0;
      off_cyc_reg <= 9'h0;
      off_ticks_reg <= 21'h0;
    end else begin
      ctrl_prev_reg <= control_in;
      if (ctrl_fall) begin
        off_cyc_reg <= 9'h0;
        off_ticks_reg <= 21'h0;
      end else if (!control_in) begin
        if (off_cyc_reg != 9'(`CST_MIN_OFF_CYC)) begin
          off_cyc_reg <= off_cyc_reg + 9'h1;
        end
        if (share_fall && off_ticks_reg != {21{1'b1}}) begin
          off_ticks_reg <= off_ticks_reg + 21'h1;
        end
      end
    end
  end

  // Hold runs from the real active edge to the virtual one
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hold_reg <= 1'b0;
      hold_cnt_reg <= 21'h0;
    end else if (restart_hit) begin
      hold_reg <= 1'b1;
      hold_cnt_reg <= 21'h0;
    end else if (hold_reg) begin
      if (hold_cnt_reg >= restart_ticks) begin
        hold_reg <= 1'b0;
      end else if (share_fall) begin
        hold_cnt_reg <= hold_cnt_reg + 21'h1;
      end
    end
  end

  // ********************
  // Requests
  // ********************
  logic vin_block;
  logic force_off;
  logic on_req;
  logic toff_tick;
  // Release of the shared line clears the block and restarts sequencing
  assign vin_block = vin_share_en_in && share_held_low;
  assign force_off = hold_reg || vin_block;
  assign on_req = control_in && operation_on_in && !force_off;
  assign toff_tick = share_present ? share_fall : osc_tick;
  // ********************
  // Channel sequencers
  // ********************
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    cst_state_type st_reg;
    logic [20:0] seq_cnt_reg;
    logic [20:0] run_cnt_reg;
    logic uv_masked_reg;
    logic fault_reg;
    logic [20:0] ton_ticks;
    logic [20:0] settle_ticks;
    logic [20:0] tmax_ticks;
    logic [20:0] toff_ticks;
    logic servo;

    cst_l11_ticks u_ton_conv (
      .l11_in(ton_reg[ch]),
      .mode_in(CST_CLAMP_LONG),
      .ticks_out(ton_ticks)
    );
    cst_l11_ticks u_settle_conv (
      .l11_in(settle_reg[ch]),
      .mode_in(CST_CLAMP_SHORT),
      .ticks_out(settle_ticks)
    );
    cst_l11_ticks u_tmax_conv (
      .l11_in(tmax_reg[ch]),
      .mode_in(CST_CLAMP_SHORT),
      .ticks_out(tmax_ticks)
    );
    cst_l11_ticks u_toff_conv (
      .l11_in(toff_reg[ch]),
      .mode_in(CST_CLAMP_LONG),
      .ticks_out(toff_ticks)
    );

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        st_reg <= CST_OFF;
        seq_cnt_reg <= 21'h0;
      end else begin
        case (st_reg)
          CST_OFF: begin
            seq_cnt_reg <= 21'h0;
            if (on_req) begin
              st_reg <= CST_TON_WAIT;
            end
          end
          CST_TON_WAIT: begin
            if (!on_req) begin
              st_reg <= CST_OFF;
            end else if (seq_cnt_reg >= ton_ticks) begin
              st_reg <= CST_ENABLED;
              seq_cnt_reg <= 21'h0;
            end else if (share_fall) begin
              seq_cnt_reg <= seq_cnt_reg + 21'h1;
            end
          end
          CST_ENABLED: begin
            seq_cnt_reg <= 21'h0;
            if (force_off) begin
              st_reg <= CST_OFF;
            end else if (!on_req) begin
              st_reg <= CST_TOFF_WAIT;
            end
          end
          default: begin
            if (force_off) begin
              st_reg <= CST_OFF;
            end else if (on_req) begin
              st_reg <= CST_ENABLED;
            end else if (seq_cnt_reg >= toff_ticks) begin
              st_reg <= CST_OFF;
            end else if (toff_tick) begin
              seq_cnt_reg <= seq_cnt_reg + 21'h1;
            end
          end
        endcase
      end
    end

    // Time since enable; saturating keeps a long run from wrapping below the settle time and dropping servo
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        run_cnt_reg <= 21'h0;
      end else if (st_reg == CST_OFF || st_reg == CST_TON_WAIT) begin
        run_cnt_reg <= 21'h0;
      end else if (share_fall && run_cnt_reg != {21{1'b1}}) begin
        run_cnt_reg <= run_cnt_reg + 21'h1;
      end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        uv_masked_reg <= 1'b1;
        fault_reg <= 1'b0;
      end else if (st_reg == CST_TON_WAIT) begin
        uv_masked_reg <= 1'b1;
        fault_reg <= 1'b0;
      end else if (st_reg != CST_OFF && uv_masked_reg && !fault_reg) begin
        if (chan_in[ch].uv_ok) begin
          uv_masked_reg <= 1'b0;
        end else if (tmax_ticks != 21'h0 && run_cnt_reg >= tmax_ticks) begin
          fault_reg <= 1'b1;
        end
      end
    end

    assign servo = (st_reg == CST_ENABLED || st_reg == CST_TOFF_WAIT) &&
                   (chan_in[ch].dac_mode == `CST_DAC_MODE_SERVO) &&
                   (run_cnt_reg >= settle_ticks);

    assign chan_status_out[ch].vout_en = (st_reg == CST_ENABLED || st_reg == CST_TOFF_WAIT);
    assign chan_status_out[ch].dac_servo = servo;
    assign chan_status_out[ch].uv_masked = uv_masked_reg;
    assign chan_status_out[ch].ton_max_fault = fault_reg;

    // ********************
    // Checks
    // ********************
    a_ton_delay_honored: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      ($past(st_reg) == CST_TON_WAIT && st_reg == CST_ENABLED) |->
        $past(seq_cnt_reg >= ton_ticks))
      else $error("Enable came before turn-on delay");
    a_ton_share_only: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      (st_reg == CST_TON_WAIT && on_req && !share_fall && seq_cnt_reg < ton_ticks) |=>
        (seq_cnt_reg == $past(seq_cnt_reg)))
      else $error("Turn-on delay advanced without a timebase tick");
    a_turn_off_delay_time_honored: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      ($past(st_reg) == CST_TOFF_WAIT && st_reg == CST_OFF && !$past(force_off)) |->
        $past(seq_cnt_reg >= toff_ticks))
      else $error("Soft-off came before turn-off delay");
    a_toff_tick_source: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      (st_reg == CST_TOFF_WAIT && !force_off && !on_req && !toff_tick &&
        seq_cnt_reg < toff_ticks) |=> (seq_cnt_reg == $past(seq_cnt_reg)))
      else $error("Turn-off delay advanced on the wrong tick");
    a_servo_after_settle: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      $rose(servo) |-> (run_cnt_reg >= settle_ticks && chan_status_out[ch].vout_en))
      else $error("DAC connected before settle time");
    a_timeout_fault_set: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      (st_reg == CST_ENABLED && uv_masked_reg && !chan_in[ch].uv_ok && tmax_ticks != 21'h0 &&
        run_cnt_reg >= tmax_ticks) |=> fault_reg)
      else $error("Turn-on timeout not declared");
    a_uv_unmask_early: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      (st_reg == CST_ENABLED && chan_in[ch].uv_ok && !fault_reg) |=> !uv_masked_reg)
      else $error("Undervoltage not unmasked on reaching threshold");
    a_zero_no_timeout: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      $rose(fault_reg) |-> ($past(tmax_ticks) != 21'h0))
      else $error("Timeout fault with zero limit");
    a_restart_holds_off: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      (hold_reg && $past(hold_reg)) |-> (st_reg == CST_OFF))
      else $error("Channel on during restart hold");
  end

  a_vin_line_low: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    (vin_share_en_in && !vin_ok_in) |-> share_clk_oe_out)
    else $error("Shared line not held low on low input");
  a_restart_zero_off: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    (restart_ticks == 21'h0) |=> !$rose(hold_reg))
    else $error("Restart hold with feature disabled");
endmodule

// ==== rtl/cst_l11_ticks.sv ====
`timescale 1ns/1ps
`include "cst_cfg.svh"
module cst_l11_ticks (
  // Setting
  input wire logic [15:0] l11_in,
  input wire cst_pkg::cst_clamp_type mode_in,
  // Result
  output logic [20:0] ticks_out
);
  import cst_pkg::*;

  logic [4:0] expo;
  logic [4:0] nsh;
  logic [47:0] prod;
  logic [47:0] scaled;
  logic [47:0] lim;
  logic [47:0] rnd;

  always_comb begin
    expo = l11_in[15:`CST_L11_EXP_LSB];
    nsh = 5'(-expo);
    // Mantissa times ticks per millisecond, then scaled by the exponent
    prod = 48'(l11_in[`CST_L11_MANT_MSB-1:0]) * 48'(`CST_TICKS_PER_MS);
    if (l11_in[`CST_L11_MANT_MSB] || prod == 48'h0) begin
      scaled = 48'h0;
    end else if (!expo[4]) begin
      scaled = prod << expo;
    end else begin
      // Half a tick added before the shift rounds to the nearest 10 us
      scaled = (prod + (48'h1 << (nsh - 5'h1))) >> nsh;
    end
    lim = (mode_in == CST_CLAMP_SHORT) ? 48'(`CST_SHORT_TICKS) : 48'(`CST_LONG_TICKS);
    if (scaled > lim) begin
      scaled = lim;
    end
    rnd = scaled;
    if (mode_in == CST_CLAMP_RESTART ||
        (mode_in == CST_CLAMP_LONG && scaled > 48'(`CST_SHORT_TICKS))) begin
      // Coarse 200 us steps; the clamp is itself a whole step
      rnd = ((scaled + 48'(`CST_COARSE_TICKS / 2)) / 48'(`CST_COARSE_TICKS))
            * 48'(`CST_COARSE_TICKS);
    end
    ticks_out = rnd[20:0];
  end
endmodule

// ==== rtl/cst_pkg.sv ====
package cst_pkg;
  typedef enum logic [1:0] {
    CST_OFF = 2'b00,
    CST_TON_WAIT = 2'b01,
    CST_ENABLED = 2'b10,
    CST_TOFF_WAIT = 2'b11
  } cst_state_type;

  typedef enum logic [1:0] {
    CST_CLAMP_SHORT = 2'b00,
    CST_CLAMP_LONG = 2'b01,
    CST_CLAMP_RESTART = 2'b10
  } cst_clamp_type;

  typedef struct packed {
    logic vout_en;
    logic dac_servo;
    logic uv_masked;
    logic ton_max_fault;
  } cst_chan_status_type;

  typedef struct packed {
    logic [1:0] dac_mode;
    logic uv_ok;
  } cst_chan_input_type;
endpackage
